// file: pkg/cesl_pkg.sv
/*
 * cesl_pkg: constants and carrier types of the controller error source
 * logic. Assumes a 32-bit register port with byte addresses, one word
 * per register.
 */
package cesl_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CES      = 8'h00;
    localparam logic [7:0] ADDR_LINK_LOW = 8'h04;
    localparam logic [7:0] ADDR_EB_ADDR  = 8'h08;
    localparam logic [7:0] ADDR_EBI_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_FW_CODE  = 8'h10;

    // controller error source field positions
    localparam int CES_ALL_SEEMS_WELL_FAILURE     = 0;
    localparam int CES_AUTONOMOUS_INTERRUPT     = 1;
    localparam int CES_PAR_EVEN = 2;
    localparam int CES_PAR_ODD  = 3;
    localparam int CES_TROUBLE  = 4;
    localparam int CES_BASE_LVL = 5;
    localparam int CES_OPCODE   = 6;
    localparam int CES_FW_LO    = 7;
    localparam int CES_FW_HI    = 11;
    localparam int CES_MODE     = 12;
    localparam int CES_PARITY   = 13;
    localparam int CES_SPARE    = 14;
    localparam int CES_LCLK     = 15;
    localparam int CES_HWSP0    = 16;
    localparam int CES_HWSP1    = 17;
    localparam int CES_EXT_BUS_ERROR_SUMMARY    = 18;
    localparam int CES_GRAM     = 19;
    localparam int CES_EXEC     = 20;
    localparam int CES_BP       = 21;
    localparam int CES_CLKPH    = 22;
    localparam int CES_XMM      = 23;

    // link status low field positions
    localparam int LNK_ILL_CMD  = 0;
    localparam int LNK_RX_PAR   = 1;
    localparam int LNK_RX_FRM   = 2;
    localparam int LNK_RXF_FULL = 4;
    localparam int LNK_RXF_HALF = 5;
    localparam int LNK_TXF_NE   = 6;
    localparam int LNK_ERR_SUM  = 7;
    localparam int LNK_TSA      = 8;
    localparam int LNK_TSEQ_LO  = 9;
    localparam int LNK_SSR      = 15;
    localparam int LNK_RSA      = 16;
    localparam int LNK_RSEQ_LO  = 17;
    localparam int LNK_NOC      = 22;

    // bit of the extended bus interface control register
    localparam int EBI_SET_STATUS = 17;

    localparam logic [23:0] CES_RESET  = 24'h000000;
    localparam logic [2:0]  LNK_RESET  = 3'h0;
    localparam logic [3:0]  UNIT_RESET = 4'h0;
    localparam int          UNITS      = 16;

    // error events, each a one-cycle pulse or a level
    typedef struct packed {
        logic        pbus_even_parity_fail;
        logic        pbus_odd_parity_fail;
        logic        unit_detected_error;
        logic        digit_buffer_overflow;
        logic        invalid_opcode;
        logic        iface_mode_failure;
        logic        iface_parity_error;
        logic        spare_error_input;
        logic        local_clock_failure;
        logic [1:0]  hardware_spare_input;
        logic        ext_bus_error_summary;
        logic        global_memory_error_summary;
        logic [15:0] exec_error_source;
        logic        backplane_error_summary;
        logic        clock_phase_error;
        logic        cross_controller_mismatch;
    } cesl_err_s;

    // link status from the extended bus interface
    typedef struct packed {
        logic             unit_illegal_command;
        logic             unit_rx_parity_error;
        logic             unit_rx_frame_error;
        logic             unit_rx_fifo_full;
        logic             unit_rx_fifo_half;
        logic             unit_tx_fifo_nonempty;
        logic [UNITS-1:0] unit_error;
        logic             tx_seq_active;
        logic [5:0]       tx_seq_state;
        logic             rx_seq_active;
        logic [4:0]       rx_seq_state;
        logic             near_op_complete;
    } cesl_link_s;

endpackage

// file: design/cesl_top.sv
/*
 * cesl_top: controller error source register, link status low word and
 * the failure flags toward the host. Assumes all inputs synchronous to
 * REF_CLK and a register master that never issues read and write at once.
 */
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module cesl_top (
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  CLK_EN,
    input  wire logic [7:0]            REG_ADDR,
    input  wire logic [31:0]           REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [31:0]           REG_RDATA,
    input  wire logic                  ORDER_ACTIVE,
    input  wire cesl_pkg::cesl_err_s   ERR_IN,
    input  wire cesl_pkg::cesl_link_s  LINK_IN,
    output logic                       UNIT_FAIL,
    output logic                       AUTO_UNIT_FAIL,
    output logic                       EBI_SEL
);

    logic [23:0] ces_r;
    logic [23:0] ces_nxt;
    logic [2:0]  lnk_err_r;
    logic [2:0]  lnk_err_nxt;
    logic [3:0]  unit_r;
    logic [3:0]  unit_nxt;
    logic        set_status_r;
    logic        set_status_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [23:0] ev;
    logic        raise;
    logic        force_fail;
    logic [23:0] link_low;
    logic        wr_ces;
    logic        wr_link;
    logic        wr_fw;
    logic [4:0]  fw_code;

    // register write decode
    assign wr_ces  = REG_WR && (REG_ADDR == cesl_pkg::ADDR_CES);
    assign wr_link = REG_WR && (REG_ADDR == cesl_pkg::ADDR_LINK_LOW);
    assign wr_fw   = REG_WR && (REG_ADDR == cesl_pkg::ADDR_FW_CODE);
    assign fw_code = wr_fw ? REG_WDATA[4:0] : 5'h0;

    // map incoming events onto their error source bits
    always_comb begin
        ev = 24'h000000;
        ev[cesl_pkg::CES_PAR_EVEN] = ERR_IN.pbus_even_parity_fail;
        ev[cesl_pkg::CES_PAR_ODD]  = ERR_IN.pbus_odd_parity_fail;
        ev[cesl_pkg::CES_TROUBLE]  = ERR_IN.unit_detected_error
                                   | ERR_IN.digit_buffer_overflow;
        ev[cesl_pkg::CES_BASE_LVL] = 1'b0;
        ev[cesl_pkg::CES_OPCODE]   = ERR_IN.invalid_opcode;
        ev[cesl_pkg::CES_FW_HI:cesl_pkg::CES_FW_LO] = fw_code;
        ev[cesl_pkg::CES_MODE]     = ERR_IN.iface_mode_failure;
        ev[cesl_pkg::CES_PARITY]   = ERR_IN.iface_parity_error;
        ev[cesl_pkg::CES_SPARE]    = ERR_IN.spare_error_input;
        ev[cesl_pkg::CES_LCLK]     = ERR_IN.local_clock_failure;
        ev[cesl_pkg::CES_HWSP0]    = ERR_IN.hardware_spare_input[0];
        ev[cesl_pkg::CES_HWSP1]    = ERR_IN.hardware_spare_input[1];
        ev[cesl_pkg::CES_EXT_BUS_ERROR_SUMMARY]    = ERR_IN.ext_bus_error_summary;
        ev[cesl_pkg::CES_GRAM]     = ERR_IN.global_memory_error_summary;
        ev[cesl_pkg::CES_EXEC]     = |ERR_IN.exec_error_source;
        ev[cesl_pkg::CES_BP]       = ERR_IN.backplane_error_summary;
        ev[cesl_pkg::CES_CLKPH]    = ERR_IN.clock_phase_error;
        ev[cesl_pkg::CES_XMM]      = ERR_IN.cross_controller_mismatch;
    end

    // bus parity, opcode and mode faults always fail the order path;
    // the rest pick interrupt or failure from the order state, and
    // trouble is reported on its own bit and carries no failure
    always_comb begin
        force_fail = ev[cesl_pkg::CES_PAR_EVEN]
                   | ev[cesl_pkg::CES_PAR_ODD]
                   | ev[cesl_pkg::CES_OPCODE]
                   | ev[cesl_pkg::CES_MODE];
        raise = 1'b0;
        for (int i = cesl_pkg::CES_PAR_EVEN; i < 24; i++) begin
            if (i != cesl_pkg::CES_TROUBLE && i != cesl_pkg::CES_PAR_EVEN
                && i != cesl_pkg::CES_PAR_ODD && i != cesl_pkg::CES_OPCODE
                && i != cesl_pkg::CES_MODE && ev[i]) begin
                raise = 1'b1;
            end
        end
    end

    // next error source word: set wins over write-one-to-clear
    always_comb begin
        ces_nxt = ces_r;
        if (wr_ces) begin
            ces_nxt = ces_r & ~REG_WDATA[23:0];
        end
        ces_nxt = ces_nxt | ev;
        if (force_fail) begin
            ces_nxt[cesl_pkg::CES_ALL_SEEMS_WELL_FAILURE] = 1'b1;
        end
        if (raise) begin
            if (ORDER_ACTIVE) begin
                ces_nxt[cesl_pkg::CES_ALL_SEEMS_WELL_FAILURE] = 1'b1;
            end else begin
                ces_nxt[cesl_pkg::CES_AUTONOMOUS_INTERRUPT] = 1'b1;
            end
        end
        ces_nxt[cesl_pkg::CES_BASE_LVL] = 1'b0;
    end

    // sticky link error bits, cleared by writing ones
    always_comb begin
        lnk_err_nxt = lnk_err_r;
        if (wr_link) begin
            lnk_err_nxt = lnk_err_r & ~REG_WDATA[2:0];
        end
        lnk_err_nxt[cesl_pkg::LNK_ILL_CMD] =
            lnk_err_nxt[cesl_pkg::LNK_ILL_CMD]
            | LINK_IN.unit_illegal_command;
        lnk_err_nxt[cesl_pkg::LNK_RX_PAR] =
            lnk_err_nxt[cesl_pkg::LNK_RX_PAR]
            | LINK_IN.unit_rx_parity_error;
        lnk_err_nxt[cesl_pkg::LNK_RX_FRM] =
            lnk_err_nxt[cesl_pkg::LNK_RX_FRM]
            | LINK_IN.unit_rx_frame_error;
    end

    // unit address and control registers, plain read/write
    always_comb begin
        unit_nxt       = unit_r;
        set_status_nxt = set_status_r;
        if (REG_WR && (REG_ADDR == cesl_pkg::ADDR_EB_ADDR)) begin
            unit_nxt = REG_WDATA[3:0];
        end
        if (REG_WR && (REG_ADDR == cesl_pkg::ADDR_EBI_CTRL)) begin
            set_status_nxt = REG_WDATA[cesl_pkg::EBI_SET_STATUS];
        end
    end

    // assembled link status low word
    always_comb begin
        link_low = 24'h000000;
        link_low[2:0] = lnk_err_r;
        link_low[cesl_pkg::LNK_RXF_FULL] = LINK_IN.unit_rx_fifo_full;
        link_low[cesl_pkg::LNK_RXF_HALF] = LINK_IN.unit_rx_fifo_half;
        link_low[cesl_pkg::LNK_TXF_NE] = LINK_IN.unit_tx_fifo_nonempty;
        link_low[cesl_pkg::LNK_ERR_SUM] = LINK_IN.unit_error[unit_r];
        link_low[cesl_pkg::LNK_TSA] = LINK_IN.tx_seq_active;
        link_low[cesl_pkg::LNK_TSEQ_LO +: 6] = LINK_IN.tx_seq_state;
        link_low[cesl_pkg::LNK_SSR] = set_status_r;
        link_low[cesl_pkg::LNK_RSA] = LINK_IN.rx_seq_active;
        link_low[cesl_pkg::LNK_RSEQ_LO +: 5] = LINK_IN.rx_seq_state;
        link_low[cesl_pkg::LNK_NOC] = LINK_IN.near_op_complete;
    end

    // read mux; the answer is held until the next read
    always_comb begin
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            case (REG_ADDR)
                cesl_pkg::ADDR_CES:
                    rdata_nxt = {8'h00, ces_r};
                cesl_pkg::ADDR_LINK_LOW:
                    rdata_nxt = {8'h00, link_low};
                cesl_pkg::ADDR_EB_ADDR:
                    rdata_nxt = {28'h0000000, unit_r};
                cesl_pkg::ADDR_EBI_CTRL:
                    rdata_nxt = {14'h0000, set_status_r, 17'h00000};
                cesl_pkg::ADDR_FW_CODE:
                    rdata_nxt = {27'h0000000,
                        ces_r[cesl_pkg::CES_FW_HI:cesl_pkg::CES_FW_LO]};
                default:
                    rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // state registers; the clock enable freezes everything but the synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ces_r        <= cesl_pkg::CES_RESET;
            lnk_err_r    <= cesl_pkg::LNK_RESET;
            unit_r       <= cesl_pkg::UNIT_RESET;
            set_status_r <= 1'b0;
            rdata_r      <= 32'h00000000;
        end else if (CLK_EN) begin
            ces_r        <= ces_nxt;
            lnk_err_r    <= lnk_err_nxt;
            unit_r       <= unit_nxt;
            set_status_r <= set_status_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign REG_RDATA      = rdata_r;
    assign UNIT_FAIL      = ces_r[cesl_pkg::CES_ALL_SEEMS_WELL_FAILURE];
    assign AUTO_UNIT_FAIL = ces_r[cesl_pkg::CES_AUTONOMOUS_INTERRUPT];
    assign EBI_SEL        = unit_r[3];

endmodule // cesl_top

// file: verif/cesl_top_properties.sv
/* cesl_props: port-level checker for cesl_top, attached by bind.
   assumes one clock REF_CLK and synchronous active-high SYS_RST. */
`timescale 1ns/1ps
module cesl_props (
    input wire logic                 REF_CLK,
    input wire logic                 SYS_RST,
    input wire logic                 CLK_EN,
    input wire logic [7:0]           REG_ADDR,
    input wire logic [31:0]          REG_WDATA,
    input wire logic                 REG_WR,
    input wire logic                 REG_RD,
    input wire logic [31:0]          REG_RDATA,
    input wire logic                 ORDER_ACTIVE,
    input wire cesl_pkg::cesl_err_s  ERR_IN,
    input wire cesl_pkg::cesl_link_s LINK_IN,
    input wire logic                 UNIT_FAIL,
    input wire logic                 AUTO_UNIT_FAIL,
    input wire logic                 EBI_SEL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    logic                 rd_ces;
    logic                 rd_lnk;
    logic [1:0]           flg_d;
    logic                 wd3_d;
    cesl_pkg::cesl_link_s lnk_d;
    // strobes the block really takes
    assign rd_ces = CLK_EN && REG_RD && REG_ADDR == cesl_pkg::ADDR_CES;
    assign rd_lnk = CLK_EN && REG_RD && REG_ADDR == cesl_pkg::ADDR_LINK_LOW;
    // one cycle of history, read data refers to the strobe edge
    always_ff @(posedge REF_CLK) begin
        flg_d <= {AUTO_UNIT_FAIL, UNIT_FAIL};
        wd3_d <= REG_WDATA[3];
        lnk_d <= LINK_IN;
    end
    a_flags_read: assert property (rd_ces |=> REG_RDATA[1:0] == flg_d)
        else $error("flag outputs differ from error word");
    a_base_clear: assert property (rd_ces |=> !REG_RDATA[5])
        else $error("unused error bit read as set");
    a_opcode_fail: assert property (CLK_EN && ERR_IN.invalid_opcode
        |=> UNIT_FAIL) else $error("opcode error without unit failure");
    a_parity_fail: assert property (CLK_EN && (ERR_IN.iface_mode_failure
        || ERR_IN.pbus_even_parity_fail || ERR_IN.pbus_odd_parity_fail)
        |=> UNIT_FAIL) else $error("bus fault without unit failure");
    a_idle_auto: assert property (CLK_EN && !ORDER_ACTIVE
        && (ERR_IN.clock_phase_error || |ERR_IN.exec_error_source)
        |=> AUTO_UNIT_FAIL) else $error("idle error not autonomous");
    a_order_fail: assert property (CLK_EN && ORDER_ACTIVE
        && ERR_IN.local_clock_failure |=> UNIT_FAIL)
        else $error("order error without unit failure");
    a_flag_sticky: assert property (UNIT_FAIL && !(CLK_EN && REG_WR
        && REG_ADDR == cesl_pkg::ADDR_CES && REG_WDATA[0]) |=> UNIT_FAIL)
        else $error("unit failure dropped without clear");
    a_unit_select: assert property (CLK_EN && REG_WR
        && REG_ADDR == cesl_pkg::ADDR_EB_ADDR |=> EBI_SEL == wd3_d)
        else $error("interface select wrong for unit");
    a_link_fifo: assert property (rd_lnk |=> REG_RDATA[6:3] ==
        {lnk_d.unit_tx_fifo_nonempty, lnk_d.unit_rx_fifo_half,
         lnk_d.unit_rx_fifo_full, 1'h0}) else $error("fifo bits wrong");
    a_link_seq: assert property (rd_lnk |=> REG_RDATA[22:16] ==
        {lnk_d.near_op_complete, lnk_d.rx_seq_state, lnk_d.rx_seq_active})
        else $error("receive sequencer bits wrong");
    c_ces_fail: cover property (rd_ces && UNIT_FAIL);
    c_order_op: cover property (CLK_EN && ORDER_ACTIVE && ERR_IN.invalid_opcode);
    c_high_unit: cover property (rd_lnk && EBI_SEL);
endmodule // cesl_props

bind cesl_top cesl_props u_props (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .ORDER_ACTIVE(ORDER_ACTIVE), .ERR_IN(ERR_IN), .LINK_IN(LINK_IN),
    .UNIT_FAIL(UNIT_FAIL), .AUTO_UNIT_FAIL(AUTO_UNIT_FAIL),
    .EBI_SEL(EBI_SEL));

// file: verif/cesl_unit_model.sv
/* cesl_unit_model: service unit side of the extended bus link.
   assumes the bench commands error pulses and per-unit error levels. */
`timescale 1ns/1ps
module cesl_unit_model (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [2:0]           err_pulse,
    input  wire logic [15:0]          unit_err,
    output cesl_pkg::cesl_link_s      link
);
    logic [15:0] st_r;
    logic [15:0] st_nxt;
    // a busy link: fifo and sequencer levels move every cycle
    always_comb begin
        st_nxt = rst ? 16'h0000 : st_r * 16'h6255 + 16'h3619;
    end
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end
    // errors first, then fifo levels, unit errors, sequencer state
    assign link = {err_pulse, st_r[15:13], unit_err, st_r[13:0]};
endmodule // cesl_unit_model

// file: verif/cesl_top_tb.sv
/* cesl_top_tb: random and corner stimulus for cesl_top, self-checking.
   assumes the unit model on the link and the bound port checker. */
`timescale 1ns/1ps
module cesl_top_tb;
    logic                 clk = 0, rst = 1, en = 1, wr = 0, rd = 0, ord = 0;
    logic [7:0]           adr = 8'h00;
    logic [31:0]          wd = 32'h0, rdat, got, ex;
    logic [2:0]           lerr = 3'h0;
    logic [15:0]          uerr = 16'h0;
    logic                 uf, auf, sel;
    cesl_pkg::cesl_err_s  ev = '0;
    cesl_pkg::cesl_link_s lnk, lsn;
    integer               seed = 56, n_mismatch = 0, check_count = 0;
    integer               k, b, p;
    int pos[17] = '{0,1,2,3,19,20,21,22,23,24,25,26,27,28,29,30,31};
    int cb[17] = '{23,22,21,20,19,18,16,17,15,14,13,12,6,4,4,3,2};
    cesl_top dut (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .REG_ADDR(adr),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .ORDER_ACTIVE(ord), .ERR_IN(ev), .LINK_IN(lnk), .UNIT_FAIL(uf),
        .AUTO_UNIT_FAIL(auf), .EBI_SEL(sel));
    cesl_unit_model far (.clk(clk), .rst(rst), .err_pulse(lerr),
        .unit_err(uerr), .link(lnk));
    // expected low link word from the snapshot the read edge samples
    function automatic logic [31:0] lw(input cesl_pkg::cesl_link_s l,
        input logic [3:0] u, input logic ss, input logic [2:0] st);
        return {9'h000, l.near_op_complete, l.rx_seq_state, l.rx_seq_active,
            ss, l.tx_seq_state, l.tx_seq_active, l.unit_error[u],
            l.unit_tx_fifo_nonempty, l.unit_rx_fifo_half,
            l.unit_rx_fifo_full, 1'h0, st};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // read data appears in the cycle after the strobe and is held until the next read
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        adr <= a;
        rd <= 1'h1;
        #50 lsn = lnk;
        @(posedge clk);
        rd <= 1'h0;
        #1 got = rdat;
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #50 clk = ~clk;
    // hang guard, far beyond the length of the sequence
    initial begin
        #2000000 n_mismatch++;
        close_out;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        // every error source once idle, once during an order
        for (k = 0; k < 34; k++) begin
            b = k % 17;
            p = (b == 3) ? 3 + $unsigned($random(seed)) % 16 : pos[b];
            @(posedge clk);
            ord <= k >= 17;
            ev <= cesl_pkg::cesl_err_s'(32'h1 << p);
            @(posedge clk);
            ev <= '0;
            repeat ($unsigned($random(seed)) % 4) @(posedge clk);
            rd_reg(cesl_pkg::ADDR_CES);
            ex = 32'h1 << cb[b];
            if (cb[b] inside {2, 3, 6, 12} || (cb[b] != 4 && k >= 17))
                ex[0] = 1'h1;
            else if (cb[b] != 4)
                ex[1] = 1'h1;
            chk("error word", ex, got);
            chk("flags", {30'h0, ex[1:0]}, {30'h0, auf, uf});
            chk("error bit", ex, got);
            wr_reg(cesl_pkg::ADDR_CES, 32'hFFFFFF);
        end
        // firmware error codes, idle and during an order
        for (k = 0; k < 4; k++) begin
            b = 1 + $unsigned($random(seed)) % 31;
            ord <= k[0];
            wr_reg(cesl_pkg::ADDR_FW_CODE, b);
            rd_reg(cesl_pkg::ADDR_CES);
            ex = {20'h0, b[4:0], 7'h0} | (k[0] ? 32'h1 : 32'h2);
            chk("firmware code", ex, got);
            wr_reg(cesl_pkg::ADDR_CES, 32'hFFFFFF);
        end
        // unmapped place: write ignored, read gives zero
        wr_reg(8'hFC, 32'hFFFFFFFF);
        rd_reg(8'hFC);
        chk("unmapped", 32'h0, got);
        rd_reg(cesl_pkg::ADDR_CES);
        chk("cleared word", 32'h0, got);
        // every unit address with random link errors and status bit
        for (k = 0; k < 16; k++) begin
            b = $random(seed);
            uerr <= b[15:0];
            wr_reg(cesl_pkg::ADDR_EB_ADDR, k);
            wr_reg(cesl_pkg::ADDR_EBI_CTRL, {14'h0, b[17], 17'h0});
            lerr <= b[20:18];
            @(posedge clk);
            lerr <= 3'h0;
            rd_reg(cesl_pkg::ADDR_LINK_LOW);
            chk("unit select", {31'h0, k[3]}, {31'h0, sel});
            ex = lw(lsn, k[3:0], b[17], {b[18], b[19], b[20]});
            chk("link word", ex, got);
            wr_reg(cesl_pkg::ADDR_LINK_LOW, 32'h7);
        end
        close_out;
    end
endmodule // cesl_top_tb
